/* inc/fmc_pkg.sv */
// Constants shared by the flash control register block and its address map.
package fmc_pkg;
    // Byte addresses of the five control registers.
    localparam logic [15:0] ADDR_MODE = 16'hf020;
    localparam logic [15:0] ADDR_ERR = 16'hf021;
    localparam logic [15:0] ADDR_PWR = 16'hf022;
    localparam logic [15:0] ADDR_EBS = 16'hf023;
    localparam logic [15:0] ADDR_ENA = 16'hf02b;
    // Upper address bits that select the register window.
    localparam logic [11:0] ADDR_WINDOW = 12'hf02;
    // Value of every register after reset.
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Bit positions in the mode control register.
    localparam int GATE_BIT = 6;
    localparam int ESU_BIT = 5;
    localparam int PSU_BIT = 4;
    localparam int EV_BIT = 3;
    localparam int PV_BIT = 2;
    localparam int ERS_BIT = 1;
    localparam int PRG_BIT = 0;
    // Error flag and power-down disable bit positions.
    localparam int FLER_BIT = 7;
    localparam int PDWND_BIT = 7;
    // Block select bits that exist in the small variant.
    localparam logic [7:0] EBS_SMALL_MASK = 8'h1f;
    // Exclusive end address of each erase block, ascending.
    localparam logic [15:0] BLK_END [8] = '{16'h0400, 16'h0800, 16'h0c00, 16'h1000,
                                            16'h8000, 16'hc000, 16'he000, 16'hf000};
    // Low address bits that must be zero at the start of a program unit.
    localparam logic [6:0] UNIT_OFFSET_ZERO = 7'h00;
    // Low-time of the sync byte counts start bit plus eight zero data bits.
    localparam logic [15:0] BAUD_LOW_BITS = 16'h0009;
    // Cycles after reset release before the boot strap is sampled.
    localparam logic [2:0] STRAP_WAIT = 3'h4;
    // Two-state register bus phases.
    typedef enum logic {BUS_IDLE = 1'b0, BUS_ANSWER = 1'b1} fmc_bus_t;
endpackage : fmc_pkg

/* inc/fmc_map_if.sv */
// Carrier between the register block and the flash address map.
`timescale 1ns/10ps
interface fmc_map_if;
    logic [15:0] addr;        // Array address under test.
    logic [7:0] blocks_sel;   // Selected erase blocks.
    logic [7:0] block_hit;    // One-hot block holding addr.
    logic in_range;           // Addr lies inside the array.
    logic aligned;            // Addr starts a program unit.
    logic erasable;           // Addr lies in a selected block.
    modport core (output addr, output blocks_sel,
                  input block_hit, input in_range, input aligned, input erasable);
    modport map (input addr, input blocks_sel,
                 output block_hit, output in_range, output aligned, output erasable);
endinterface : fmc_map_if

/* logic/fmc_block_map.sv */
// Combinational map from an array address to its erase block and program unit.
`timescale 1ns/10ps
module fmc_block_map #(
    parameter bit LARGE = 1'b1
) (
    fmc_map_if.map m
);
    // The small variant stops after the fifth block.
    localparam int NBLK = LARGE ? 8 : 5;

    // Find the block whose range holds the address.
    always_comb
    begin
        logic [15:0] lo;
        lo = 16'h0000;
        m.block_hit = 8'h00;
        m.in_range = 1'b0;
        for (int i = 0; i < NBLK; i++)
        begin
            // Blocks are contiguous, so each starts where the last ended.
            if (m.addr >= lo && m.addr < fmc_pkg::BLK_END[i])
            begin
                m.block_hit[i] = 1'b1;
                m.in_range = 1'b1;
            end
            lo = fmc_pkg::BLK_END[i];
        end
    end

    // A unit starts where the low eight bits read 00 or 80.
    assign m.aligned = m.in_range && (m.addr[6:0] == fmc_pkg::UNIT_OFFSET_ZERO);
    // Erase reaches only blocks that are selected.
    assign m.erasable = |(m.block_hit & m.blocks_sel);
endmodule : fmc_block_map

/* logic/fmc_regs.sv */
// Flash control registers, mode gating, strap capture and boot bit-rate detect.
// What this block does
// - Program units are 128 bytes, 00/80 aligned.
// - Large array erases one of eight blocks.
// - Small array has four 1K, one 28K block.
// - Boot loader covers array; user mode per block.
// - Boot transfer bit rate follows the host.
// - All five control registers are eight bits.
// - Byte accesses only, answered in two states.
// - Without flash, reads undefined, writes ignored.
// - Mode bits select program, erase, verify modes.
// - Mode register top bit reads zero always.
// - Gate clear blocks other mode bits and block select.
// - Gate set permits programming, erasing, control.
// - Subactive powers down; array stays readable.
// - External programmer mode also programs array.
// - Erase mode needs gate and erase setup.
// - Program mode needs gate and program setup.
// - Block select clears on gate off, multi-set.
`timescale 1ns/10ps
module fmc_regs #(
    parameter bit FLASH_PRESENT = 1'b1,
    parameter bit LARGE = 1'b1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic bus_sel,
    input wire logic bus_write,
    input wire logic bus_byte,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic bus_ack,
    input wire logic array_error,
    input wire logic [15:0] array_addr,
    input wire logic subactive,
    input wire logic boot_pin,
    input wire logic rxd_pin,
    input wire logic prog_mode_pin,
    output logic mode_program,
    output logic mode_erase,
    output logic mode_prog_verify,
    output logic mode_erase_verify,
    output logic [7:0] erase_blocks,
    output logic addr_erasable,
    output logic unit_aligned,
    output logic power_down,
    output logic array_read_en,
    output logic boot_loader_run,
    output logic [15:0] baud_period,
    output logic baud_locked,
    output logic ext_programmer
);
    fmc_pkg::fmc_bus_t bus_state; // Phase of the two-state access.
    logic software_write_gate, erase_setup, program_setup, ev, pv, ers, prg; // Mode control bits.
    logic fler;               // Sticky array error flag.
    logic pdwnd;              // Power-down disable.
    logic [7:0] flash_enable_ctl;         // Enable register contents.
    logic [7:0] ebs;          // Erase block select.
    logic [2:0] s1, s2, s3;   // Pin synchroniser stages; bits 0-2: boot, rxd, prog.
    logic [2:0] pin_f;        // Filtered pin levels.
    logic [2:0] strap_cnt;    // Wait before the boot strap is caught.
    logic strap_done;         // Strap already caught.
    logic boot;               // Captured boot strap.
    logic [15:0] low_cnt;     // Low-time of the sync byte.
    logic rxd_prev;           // Last filtered rxd level.
    logic hit, hit_ok, wr_ok; // Decoded access terms.
    logic wr_mode, wr_pwr, wr_ebs, wr_ena;
    logic [7:0] next_ebs;     // Masked block select write data; loaded only if at most one bit is set.
    logic [7:0] ebs_mask;     // Bits that exist in this variant.
    fmc_map_if map_bus ();

    // Address map; the array side address is checked against selected blocks.
    fmc_block_map #(.LARGE(LARGE)) u_map (.m(map_bus.map));
    assign map_bus.addr = array_addr;
    assign map_bus.blocks_sel = ebs;

    // Any access inside the register window is ours to answer.
    assign hit = bus_sel && (bus_state == fmc_pkg::BUS_IDLE)
                 && (bus_addr[15:4] == fmc_pkg::ADDR_WINDOW);
    // Word accesses are answered but have no effect.
    assign hit_ok = hit && bus_byte;
    // Parts without flash and the external programmer lock the registers out.
    assign wr_ok = hit_ok && bus_write && FLASH_PRESENT && !ext_programmer;
    // Each register accepts writes only at its own address.
    assign wr_mode = wr_ok && (bus_addr == fmc_pkg::ADDR_MODE);
    assign wr_pwr = wr_ok && (bus_addr == fmc_pkg::ADDR_PWR);
    assign wr_ebs = wr_ok && (bus_addr == fmc_pkg::ADDR_EBS);
    assign wr_ena = wr_ok && (bus_addr == fmc_pkg::ADDR_ENA);
    // The small variant has no block select bits above the fifth.
    assign ebs_mask = LARGE ? 8'hff : fmc_pkg::EBS_SMALL_MASK;
    assign next_ebs = bus_wdata & ebs_mask;

    // Bus phase: an access taken in the first state is answered in the second.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_state <= fmc_pkg::BUS_IDLE;
        end
        else
        begin
            unique case (bus_state)
                fmc_pkg::BUS_IDLE:
                begin
                    // Take the access and move to the answer state.
                    if (hit)
                    begin
                        bus_state <= fmc_pkg::BUS_ANSWER;
                    end
                end
                fmc_pkg::BUS_ANSWER:
                begin
                    // A request during the answer is not taken.
                    bus_state <= fmc_pkg::BUS_IDLE;
                end
            endcase
        end
    end
    assign bus_ack = (bus_state == fmc_pkg::BUS_ANSWER);

    // Read data is loaded when the access is taken and held until the next.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_rdata <= fmc_pkg::RST_BYTE;
        end
        else if (hit)
        begin
            // Absent flash and word reads give zero, a safe undefined value.
            if (!hit_ok || !FLASH_PRESENT || bus_write)
            begin
                bus_rdata <= 8'h00;
            end
            else
            begin
                unique case (bus_addr)
                    // Top bit of the mode register always reads zero.
                    fmc_pkg::ADDR_MODE: bus_rdata <= {1'b0, software_write_gate, erase_setup, program_setup, ev, pv, ers, prg};
                    fmc_pkg::ADDR_ERR: bus_rdata <= {fler, 7'h00};
                    fmc_pkg::ADDR_PWR: bus_rdata <= {pdwnd, 7'h00};
                    fmc_pkg::ADDR_EBS: bus_rdata <= ebs;
                    fmc_pkg::ADDR_ENA: bus_rdata <= flash_enable_ctl;
                    // Unlisted window addresses read as zero.
                    default: bus_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Software write gate.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            software_write_gate <= 1'b0;
        end
        else if (wr_mode)
        begin
            software_write_gate <= bus_wdata[fmc_pkg::GATE_BIT];
        end
    end

    // Remaining mode bits follow the gate as it stood before the write.
    // Using the old gate means one write cannot open the gate and set a mode.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {erase_setup, program_setup, ev, pv, ers, prg} <= 6'h00;
        end
        else if (!software_write_gate)
        begin
            // Gate closed: nothing else may be set.
            {erase_setup, program_setup, ev, pv, ers, prg} <= 6'h00;
        end
        else if (wr_mode)
        begin
            if (!bus_wdata[fmc_pkg::GATE_BIT])
            begin
                // Closing the gate drops every mode with it.
                {erase_setup, program_setup, ev, pv, ers, prg} <= 6'h00;
            end
            else
            begin
                erase_setup <= bus_wdata[fmc_pkg::ESU_BIT];
                program_setup <= bus_wdata[fmc_pkg::PSU_BIT];
                ev <= bus_wdata[fmc_pkg::EV_BIT];
                pv <= bus_wdata[fmc_pkg::PV_BIT];
                // Erase and program take hold only over a setup already made.
                ers <= bus_wdata[fmc_pkg::ERS_BIT] && erase_setup;
                prg <= bus_wdata[fmc_pkg::PRG_BIT] && program_setup;
            end
        end
    end

    // Array mode outputs; the external programmer owns the array instead.
    always_comb
    begin
        mode_erase = software_write_gate && erase_setup && ers && !ext_programmer;
        mode_program = software_write_gate && program_setup && prg && !ext_programmer;
        mode_erase_verify = software_write_gate && ev && !ext_programmer;
        mode_prog_verify = software_write_gate && pv && !ext_programmer;
    end
    // The array reads as ROM whenever it is not being altered.
    assign array_read_en = !(mode_erase || mode_program);

    // Erase block select; more than one bit set clears them all.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ebs <= fmc_pkg::RST_BYTE;
        end
        else if (!software_write_gate)
        begin
            ebs <= 8'h00;
        end
        else if (wr_ebs)
        begin
            ebs <= $onehot0(next_ebs) ? next_ebs : 8'h00;
        end
    end
    assign erase_blocks = ebs;

    // Error flag is set by the array and cleared only by reset.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fler <= 1'b0;
        end
        else if (array_error)
        begin
            fler <= 1'b1;
        end
    end

    // Power control and enable registers.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pdwnd <= 1'b0;
            flash_enable_ctl <= fmc_pkg::RST_BYTE;
        end
        else
        begin
            if (wr_pwr)
            begin
                pdwnd <= bus_wdata[fmc_pkg::PDWND_BIT];
            end
            if (wr_ena)
            begin
                flash_enable_ctl <= bus_wdata;
            end
        end
    end
    // Supply is partly halted in subactive mode unless disabled.
    assign power_down = subactive && !pdwnd;

    // Pin synchronisers; a change counts once stages two and three agree.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1 <= 3'h0;
            s2 <= 3'h0;
            s3 <= 3'h0;
            pin_f <= 3'h0;
        end
        else
        begin
            s1 <= {prog_mode_pin, rxd_pin, boot_pin};
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < 3; i++)
            begin
                if (s2[i] == s3[i])
                begin
                    pin_f[i] <= s3[i];
                end
            end
        end
    end
    assign ext_programmer = pin_f[2];

    // Boot strap is caught once the synchroniser has settled after reset.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_cnt <= 3'h0;
            strap_done <= 1'b0;
            boot <= 1'b0;
        end
        else if (!strap_done)
        begin
            if (strap_cnt == fmc_pkg::STRAP_WAIT)
            begin
                strap_done <= 1'b1;
                boot <= pin_f[0];
            end
            else
            begin
                strap_cnt <= strap_cnt + 3'h1;
            end
        end
    end
    assign boot_loader_run = boot;

    // Boot bit rate: time the sync byte's low run and divide by its bit count.
    // Only the first byte is measured; a noisy line locks a wrong rate.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            low_cnt <= 16'h0000;
            rxd_prev <= 1'b1;
            baud_period <= 16'h0000;
            baud_locked <= 1'b0;
        end
        else if (boot && !baud_locked)
        begin
            rxd_prev <= pin_f[1];
            if (!pin_f[1] && low_cnt != 16'hffff)
            begin
                low_cnt <= low_cnt + 16'h0001;
            end
            else if (pin_f[1] && !rxd_prev && low_cnt != 16'h0000)
            begin
                baud_period <= low_cnt / fmc_pkg::BAUD_LOW_BITS;
                baud_locked <= 1'b1;
            end
        end
    end

    // Array-side address checks; boot mode may reach the whole array.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addr_erasable <= 1'b0;
            unit_aligned <= 1'b0;
        end
        else
        begin
            addr_erasable <= boot ? map_bus.in_range : map_bus.erasable;
            unit_aligned <= map_bus.aligned;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // A taken access and its answer in the next state.
    sequence s_taken;
        hit && bus_byte;
    endsequence
    sequence s_answered;
        bus_ack ##1 !bus_ack;
    endsequence
    property p_two_state;
        s_taken |=> s_answered;
    endproperty
    a_two_state: assert property (p_two_state) else $error("access not two-state");

    property p_top_zero;
        hit && !bus_write && bus_addr == fmc_pkg::ADDR_MODE |=> !bus_rdata[7];
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("mode top bit read one");

    property p_gate_off;
        !software_write_gate |=> (ebs == 8'h00) && !erase_setup && !program_setup && !ev && !pv && !ers && !prg;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("bits set with gate off");

    property p_erase_entry;
        $rose(ers) |-> $past(erase_setup) && $past(software_write_gate);
    endproperty
    a_erase_entry: assert property (p_erase_entry) else $error("erase without setup");

    property p_prog_entry;
        $rose(prg) |-> $past(program_setup) && $past(software_write_gate);
    endproperty
    a_prog_entry: assert property (p_prog_entry) else $error("program without setup");

    property p_multi_sel;
        wr_ebs && software_write_gate && !$onehot0(next_ebs) |=> ebs == 8'h00;
    endproperty
    a_multi_sel: assert property (p_multi_sel) else $error("multi block select kept");

    property p_small_blocks;
        !LARGE |-> ebs[7:5] == 3'h0;
    endproperty
    a_small_blocks: assert property (p_small_blocks) else $error("small part block high");

    sequence s_pd_disabled;
        wr_pwr && bus_wdata[fmc_pkg::PDWND_BIT] ##1 subactive;
    endsequence
    property p_pd_disable;
        s_pd_disabled |-> !power_down;
    endproperty
    a_pd_disable: assert property (p_pd_disable) else $error("power down not disabled");

    property p_unmapped;
        hit && bus_write && bus_addr[3:0] > 4'h3 && bus_addr[3:0] != 4'hb
            |=> $stable(ebs) && $stable(pdwnd) && $stable(flash_enable_ctl) && $stable(software_write_gate);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unlisted address wrote");

    property p_aligned;
        unit_aligned |-> $past(array_addr[6:0]) == 7'h00;
    endproperty
    a_aligned: assert property (p_aligned) else $error("unaligned unit flagged");

    property p_ext_lock;
        ext_programmer |-> !mode_program && !mode_erase;
    endproperty
    a_ext_lock: assert property (p_ext_lock) else $error("mode on under programmer");
endmodule : fmc_regs

/* sim/tb.sv */
// Self-checking bench for the flash control register block.
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0; // Bench clock, 25 ns period.
    logic arst_n = 1'b0; // Reset starts asserted.
    logic bus_sel = 1'b0;
    logic bus_write = 1'b0;
    logic bus_byte = 1'b1;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00;
    logic array_error = 1'b0;
    logic [15:0] array_addr = 16'h0000;
    logic subactive = 1'b0;
    logic boot_pin = 1'b0; // Held steady across each reset so the strap is clean.
    logic rxd_pin = 1'b1; // Serial line idles high.
    logic prog_mode_pin = 1'b0;
    logic [7:0] bus_rdata, erase_blocks;
    logic bus_ack, mode_program, mode_erase, mode_prog_verify, mode_erase_verify;
    logic addr_erasable, unit_aligned, power_down, array_read_en;
    logic boot_loader_run, baud_locked, ext_programmer;
    logic [15:0] baud_period;
    int n_fail = 0; // Mismatches seen.
    int n_tests = 0; // Comparisons made.

    // Free-running clock at 40 MHz.
    always #12.5 clk = ~clk;

    fmc_regs #(.FLASH_PRESENT(1'b1), .LARGE(1'b1)) dut (
        .clk(clk), .arst_n(arst_n), .bus_sel(bus_sel), .bus_write(bus_write),
        .bus_byte(bus_byte), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_ack(bus_ack), .array_error(array_error),
        .array_addr(array_addr), .subactive(subactive), .boot_pin(boot_pin),
        .rxd_pin(rxd_pin), .prog_mode_pin(prog_mode_pin), .mode_program(mode_program),
        .mode_erase(mode_erase), .mode_prog_verify(mode_prog_verify),
        .mode_erase_verify(mode_erase_verify), .erase_blocks(erase_blocks),
        .addr_erasable(addr_erasable), .unit_aligned(unit_aligned),
        .power_down(power_down), .array_read_en(array_read_en),
        .boot_loader_run(boot_loader_run), .baud_period(baud_period),
        .baud_locked(baud_locked), .ext_programmer(ext_programmer));

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // One two-state access; the request stands through the acknowledge cycle.
    task automatic access(input logic wr, input logic byt, input logic [15:0] a,
                          input logic [7:0] d, input logic ack_exp, output logic [7:0] q);
        @(negedge clk);
        bus_sel = 1'b1;
        bus_write = wr;
        bus_byte = byt;
        bus_addr = a;
        bus_wdata = d;
        @(negedge clk);
        check({15'h0000, bus_ack}, {15'h0000, ack_exp});
        q = bus_rdata;
        @(negedge clk);
        check({15'h0000, bus_ack}, 16'h0000);
        bus_sel = 1'b0;
    endtask : access

    // Byte write that must be acknowledged.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(1'b1, 1'b1, a, d, 1'b1, q);
    endtask : wr

    // Byte read compared against an expected value.
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] q;
        access(1'b0, 1'b1, a, 8'h00, 1'b1, q);
        check({8'h00, q}, {8'h00, exp});
    endtask : rd

    // Bounded wait on a status output; which selects lock (0) or programmer mode (1).
    task automatic wait_for(input int which);
        int k;
        k = 0;
        while (((which == 0) ? baud_locked : ext_programmer) !== 1'b1 && k < 400)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= 400)
        begin
            n_fail++;
            $display("Error at %0t: status wait ran out", $time);
            end_sim();
        end
    endtask : wait_for

    // Main sequence of register accesses and pin stimulus.
    initial
    begin
        logic [7:0] q;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        // Every register must come out of reset cleared.
        rd(fmc_pkg::ADDR_MODE, 8'h00);
        rd(fmc_pkg::ADDR_ERR, 8'h00);
        rd(fmc_pkg::ADDR_PWR, 8'h00);
        rd(fmc_pkg::ADDR_EBS, 8'h00);
        rd(fmc_pkg::ADDR_ENA, 8'h00);
        access(1'b1, 1'b1, 16'h1234, 8'hff, 1'b0, q);
        // With the gate closed no other mode bit or block select may be set.
        wr(fmc_pkg::ADDR_MODE, 8'h3f);
        rd(fmc_pkg::ADDR_MODE, 8'h00);
        wr(fmc_pkg::ADDR_EBS, 8'h01);
        rd(fmc_pkg::ADDR_EBS, 8'h00);
        // Open the gate; the top bit must stay zero.
        wr(fmc_pkg::ADDR_MODE, 8'hc0);
        rd(fmc_pkg::ADDR_MODE, 8'h40);
        access(1'b1, 1'b0, fmc_pkg::ADDR_MODE, 8'h00, 1'b1, q);
        rd(fmc_pkg::ADDR_MODE, 8'h40);
        wr(16'hf025, 8'h5a);
        rd(16'hf025, 8'h00);
        wr(fmc_pkg::ADDR_ENA, 8'ha5);
        rd(fmc_pkg::ADDR_ENA, 8'ha5);
        wr(fmc_pkg::ADDR_EBS, 8'h03);
        rd(fmc_pkg::ADDR_EBS, 8'h00);
        // Erase bit without its setup bit must not take effect.
        wr(fmc_pkg::ADDR_MODE, 8'h42);
        rd(fmc_pkg::ADDR_MODE, 8'h40);
        wr(fmc_pkg::ADDR_MODE, 8'h60);
        wr(fmc_pkg::ADDR_MODE, 8'h62);
        check({15'h0000, mode_erase}, 16'h0001);
        check({15'h0000, array_read_en}, 16'h0000);
        wr(fmc_pkg::ADDR_MODE, 8'h50);
        wr(fmc_pkg::ADDR_MODE, 8'h51);
        check({14'h0000, mode_program, mode_erase}, 16'h0002);
        wr(fmc_pkg::ADDR_MODE, 8'h48);
        check({15'h0000, mode_erase_verify}, 16'h0001);
        wr(fmc_pkg::ADDR_MODE, 8'h44);
        check({15'h0000, mode_prog_verify}, 16'h0001);
        wr(fmc_pkg::ADDR_MODE, 8'h40);
        check({11'h000, array_read_en, mode_program, mode_erase,
               mode_prog_verify, mode_erase_verify}, 16'h0010);
        // Walk each erase block, checking its last byte and the first byte at its end address.
        // User mode reaches the whole array the only way it can: one selected block after another.
        for (int i = 0; i < 8; i++)
        begin
            wr(fmc_pkg::ADDR_EBS, 8'h01 << i);
            rd(fmc_pkg::ADDR_EBS, 8'h01 << i);
            array_addr = fmc_pkg::BLK_END[i] - 16'h0001;
            repeat (2) @(negedge clk);
            check({15'h0000, addr_erasable}, 16'h0001);
            array_addr = fmc_pkg::BLK_END[i];
            repeat (2) @(negedge clk);
            check({15'h0000, addr_erasable}, 16'h0000);
        end
        // Program units start on 128-byte boundaries only.
        array_addr = 16'h1080;
        repeat (2) @(negedge clk);
        check({15'h0000, unit_aligned}, 16'h0001);
        array_addr = 16'h10c0;
        repeat (2) @(negedge clk);
        check({15'h0000, unit_aligned}, 16'h0000);
        // Closing the gate wipes the block selection.
        wr(fmc_pkg::ADDR_MODE, 8'h00);
        check({8'h00, erase_blocks}, 16'h0000);
        rd(fmc_pkg::ADDR_EBS, 8'h00);
        // The error flag ignores writes and sticks once raised.
        wr(fmc_pkg::ADDR_ERR, 8'hff);
        rd(fmc_pkg::ADDR_ERR, 8'h00);
        @(negedge clk);
        array_error = 1'b1;
        @(negedge clk);
        array_error = 1'b0;
        rd(fmc_pkg::ADDR_ERR, 8'h80);
        // Subactive powers the array down unless the disable bit is set.
        subactive = 1'b1;
        @(negedge clk);
        check({15'h0000, power_down}, 16'h0001);
        wr(fmc_pkg::ADDR_PWR, 8'hff);
        rd(fmc_pkg::ADDR_PWR, 8'h80);
        check({15'h0000, power_down}, 16'h0000);
        subactive = 1'b0;
        // Second reset with the boot strap high.
        @(negedge clk);
        arst_n = 1'b0;
        boot_pin = 1'b1;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (12) @(negedge clk);
        check({15'h0000, boot_loader_run}, 16'h0001);
        array_addr = 16'h2000;
        repeat (2) @(negedge clk);
        check({15'h0000, addr_erasable}, 16'h0001);
        // A sync byte low for nine bit times of 20 cycles each.
        rxd_pin = 1'b0;
        repeat (180) @(negedge clk);
        rxd_pin = 1'b1;
        wait_for(0);
        check(baud_period, 16'h0014);
        // Open the gate first, so that a blocked write shows as a kept value.
        wr(fmc_pkg::ADDR_MODE, 8'h40);
        rd(fmc_pkg::ADDR_MODE, 8'h40);
        // External programmer mode locks out bus writes.
        prog_mode_pin = 1'b1;
        wait_for(1);
        wr(fmc_pkg::ADDR_MODE, 8'h00);
        rd(fmc_pkg::ADDR_MODE, 8'h40);
        check({14'h0000, mode_program, mode_erase}, 16'h0000);
        end_sim();
    end

    // Guards against a hang anywhere in the sequence.
    initial
    begin
        #(25 * 20000);
        n_fail++;
        $display("Error at %0t: run time limit reached", $time);
        end_sim();
    end
endmodule : tb
